/* core/pch_cfg.svh */
// constants for the configuration header register bank
`ifndef PCH_CFG_SVH
`define PCH_CFG_SVH
`define PCH_OFS_IDENT      8'h00
`define PCH_OFS_CMDSTAT    8'h04
`define PCH_OFS_CLASS      8'h08
`define PCH_OFS_MISC       8'h0c
`define PCH_OFS_IO_BAR     8'h10
`define PCH_OFS_MEM_BAR    8'h14
`define PCH_OFS_RAM_BAR    8'h18
`define PCH_OFS_SUBSYS     8'h2c
`define PCH_OFS_ROM_BAR    8'h30
`define PCH_OFS_CAP_PTR    8'h34
`define PCH_OFS_IRQ        8'h3c
`define PCH_OFS_PM_CAP     8'h40
`define PCH_OFS_PM_CSR     8'h44
`define PCH_OFS_UNSUP_BASE 8'h40
`define PCH_OFS_UNSUP_EXT  8'h48
`define PCH_OPREG_BIT      7
`define PCH_CMD_IO         0
`define PCH_CMD_MEM        1
`define PCH_CMD_MASTER     2
`define PCH_CMD_MWI        4
`define PCH_CMD_PERR       6
`define PCH_CMD_SERR       8
`define PCH_CMD_MASK       16'h0157
`define PCH_ST_PAR_RPT     8
`define PCH_ST_TGT_ABT     12
`define PCH_ST_MST_ABT     13
`define PCH_ST_SERR        14
`define PCH_ST_PAR_DET     15
`define PCH_ST_CAP         4
`define PCH_SEL_TIMING     2'h1
`define PCH_SEL_LO         9
`define PCH_CLASS_CODE     24'h01_0000
`define PCH_HDR_TYPE       8'h00
`define PCH_IRQ_PIN        8'h01
`define PCH_MIN_GNT        8'h11
`define PCH_MAX_LAT        8'h40
`define PCH_CAP_START      8'h40
`define PCH_CAP_PM_ID      8'h01
`define PCH_IO_BAR_MASK    32'hffff_ff00
`define PCH_MEM_BAR_MASK   32'hffff_ff00
`define PCH_RAM_BAR_MASK   32'hffff_f000
`define PCH_IO_BAR_FIX     32'h0000_0001
`define PCH_ROM_EN_BIT     0
`define PCH_RAM_STRAP_BIT  5
`define PCH_PM_STATE_MASK  16'h0003
`endif

/* core/pch_pkg.sv */
// types shared by the configuration header bank
package pch_pkg;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] data;
    } pch_cfg_req_t;
    typedef struct packed {
        logic parity_detected;
        logic serr_asserted;
        logic master_abort;
        logic target_abort;
        logic perr_on_master;
    } pch_events_t;
    typedef struct packed {
        logic io_claim_en;
        logic mem_claim_en;
        logic master_en;
        logic mwi_en;
        logic parity_resp_en;
        logic serr_drv_en;
        logic addr_par_report_en;
    } pch_enables_t;
endpackage : pch_pkg

/* core/pch_bar.sv */
// one base address register with a size mask and fixed low bits
`timescale 1ns/1ps
`include "pch_cfg.svh"
module pch_bar #(
    parameter logic [31:0] SIZE_MASK = 32'hffff_ff00,
    parameter logic [31:0] FIXED     = 32'h0000_0000
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic        enable_in,
    input  wire logic        write_in,
    input  wire logic [3:0]  byte_en_in,
    input  wire logic [31:0] data_in,
    output logic      [31:0] value_out
);
    logic [31:0] base;
    logic [31:0] lane_mask;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            lane_mask[i*8 +: 8] = {8{byte_en_in[i]}};
        end
    end
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            base <= 32'h0000_0000;
        else if (write_in && enable_in)
            base <= ((base & ~lane_mask) | (data_in & lane_mask)) & SIZE_MASK;
    end
    // disabled bar reads zero and cannot be sized
    assign value_out = enable_in ? (base | FIXED) : 32'h0000_0000;
endmodule : pch_bar

/* core/pch_config_header.sv */
// configuration header register bank with command and status logic
// Overview of operation
// - header reached only through configuration read and write cycles
// - low 128 bytes configuration data, upper 128 bytes operating registers
// - unsupported locations ignore writes and read zero
// - base variant 40h-7Fh unsupported; extended variant only 48h-7Fh
// - reserved locations read zero
// - read-only maker identity at 00h, part identity at 02h
// - command all zero: no access except configuration
// - command bits 3,5,7,9-15 have no effect
// - bit 8 enables error driver; address parity reported needs bits 8 and 6
// - bit 6 enables data parity reporting; parity always generated
// - bit 4 permits write-and-invalidate only with dma test control bit 0
// - bit 2 clear forbids starting master accesses
// - bit 1 enables claiming memory accesses in memory window
// - bit 0 enables claiming io accesses in io window
// - status reads unchanged; write-one clears; writes never set
// - status bits 0-3,5,6,7,11 read zero
// - bit 15 set on any data parity error regardless of enable
// - bit 14 set whenever error driver asserted
// - bit 13 set on own master abort except special cycle
// - ram base enabled after reset unless strap line pulled down
// - rom base functional only when straps enable expansion memory
// - bit 12 set on own transaction ended by target abort
// - bits 10-9 read select timing code medium
// - bit 8 set on error signal in own mastered transfer with bit 6 set
`timescale 1ns/1ps
`include "pch_cfg.svh"
module pch_config_header #(
    parameter bit          EXTENDED     = 1'b0,
    parameter logic [15:0] MAKER_ID     = 16'h0a5a,   // arbitrary value
    parameter logic [15:0] PART_ID      = 16'h0c3c,   // arbitrary value
    parameter logic [7:0]  REVISION     = 8'h01,      // arbitrary value
    parameter logic [15:0] BOARD_MAKER  = 16'h0000,   // arbitrary value
    parameter logic [31:0] ROM_MASK     = 32'hffff_8000
) (
    input  wire logic                 clock_in,
    input  wire logic                 reset_n_in,
    input  wire pch_pkg::pch_cfg_req_t cfg_req_in,
    output logic               [31:0] cfg_read_data_out,
    output logic                      cfg_done_out,
    output logic                      opreg_sel_out,
    input  wire logic          [31:0] opreg_read_data_in,
    input  wire logic           [7:0] strap_bus_in,
    input  wire logic                 strap_sample_in,
    input  wire logic                 dma_test_control_three_bit0_in,
    input  wire pch_pkg::pch_events_t events_in,
    input  wire logic                 special_cycle_in,
    input  wire logic                 addr_parity_err_in,
    output pch_pkg::pch_enables_t     enables_out,
    output logic                      serr_drive_out,
    output logic               [31:0] io_base_out,
    output logic               [31:0] mem_base_out,
    output logic               [31:0] ram_base_out,
    output logic               [31:0] rom_base_out
);
    logic [15:0] command;
    logic [15:0] status_flags;
    logic [7:0]  cache_line_words;
    logic [7:0]  master_latency_count;
    logic [7:0]  irq_routing_line;
    logic [15:0] power_control_state;
    logic        ram_bar_enabled;
    logic        rom_bar_enabled;
    logic        strap_taken;
    logic [31:0] io_bar_val;
    logic [31:0] mem_bar_val;
    logic [31:0] ram_bar_val;
    logic [31:0] rom_bar_val;
    logic [31:0] next_read_data;
    logic        wr;
    logic        is_opreg;
    logic [7:0]  word_ofs;
    logic [15:0] status_view;
    logic [15:0] clear_mask;
    logic [15:0] set_mask;
    logic        serr_event;
    localparam logic [15:0] CMD_KEEP = `PCH_CMD_MASK;

    // only configuration cycles reach this bank
    assign wr       = cfg_req_in.valid && cfg_req_in.write;
    assign is_opreg = cfg_req_in.offset[`PCH_OPREG_BIT];
    assign word_ofs = {cfg_req_in.offset[7:2], 2'b00};
    assign opreg_sel_out = cfg_req_in.valid && is_opreg;

    // straps are caught on a clocked edge after reset release, never in reset
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ram_bar_enabled <= 1'b1;
            rom_bar_enabled <= 1'b0;
            strap_taken     <= 1'b0;
        end
        else if (strap_sample_in && !strap_taken)
        begin
            strap_taken     <= 1'b1;
            ram_bar_enabled <= strap_bus_in[`PCH_RAM_STRAP_BIT];
            rom_bar_enabled <= ~&strap_bus_in;
        end
    end

    // command register; unimplemented bits never stored
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            command <= 16'h0000;
        else if (wr && !is_opreg && word_ofs == `PCH_OFS_CMDSTAT)
        begin
            if (cfg_req_in.byte_en[0])
                command[7:0] <= cfg_req_in.data[7:0] & CMD_KEEP[7:0];
            if (cfg_req_in.byte_en[1])
                command[15:8] <= cfg_req_in.data[15:8] & CMD_KEEP[15:8];
        end
    end

    // one process drives the whole struct so it has a single driver
    always_comb
    begin
        enables_out.io_claim_en    = command[`PCH_CMD_IO];
        enables_out.mem_claim_en   = command[`PCH_CMD_MEM];
        enables_out.master_en      = command[`PCH_CMD_MASTER];
        enables_out.mwi_en         = command[`PCH_CMD_MWI] && dma_test_control_three_bit0_in;
        enables_out.parity_resp_en = command[`PCH_CMD_PERR];
        enables_out.serr_drv_en    = command[`PCH_CMD_SERR];
        enables_out.addr_par_report_en = command[`PCH_CMD_SERR] && command[`PCH_CMD_PERR];
    end

    // error driver asserts only on enabled address parity errors
    assign serr_event = addr_parity_err_in && command[`PCH_CMD_SERR] && command[`PCH_CMD_PERR];
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            serr_drive_out <= 1'b0;
        else
            serr_drive_out <= serr_event;
    end

    // event set masks
    always_comb
    begin
        set_mask = 16'h0000;
        set_mask[`PCH_ST_PAR_DET] = events_in.parity_detected;
        set_mask[`PCH_ST_SERR]    = serr_drive_out;
        set_mask[`PCH_ST_MST_ABT] = events_in.master_abort && !special_cycle_in;
        set_mask[`PCH_ST_TGT_ABT] = events_in.target_abort;
        set_mask[`PCH_ST_PAR_RPT] = events_in.perr_on_master && command[`PCH_CMD_PERR];
    end

    always_comb
    begin
        clear_mask = 16'h0000;
        if (wr && !is_opreg && word_ofs == `PCH_OFS_CMDSTAT)
        begin
            if (cfg_req_in.byte_en[2])
                clear_mask[7:0] = cfg_req_in.data[23:16];
            if (cfg_req_in.byte_en[3])
                clear_mask[15:8] = cfg_req_in.data[31:24];
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            status_flags <= 16'h0000;
        else
            status_flags <= (status_flags & ~clear_mask) | set_mask;
    end

    always_comb
    begin
        status_view = 16'h0000;
        status_view[`PCH_ST_PAR_DET] = status_flags[`PCH_ST_PAR_DET];
        status_view[`PCH_ST_SERR]    = status_flags[`PCH_ST_SERR];
        status_view[`PCH_ST_MST_ABT] = status_flags[`PCH_ST_MST_ABT];
        status_view[`PCH_ST_TGT_ABT] = status_flags[`PCH_ST_TGT_ABT];
        status_view[`PCH_ST_PAR_RPT] = status_flags[`PCH_ST_PAR_RPT];
        status_view[`PCH_SEL_LO +: 2] = `PCH_SEL_TIMING;
        status_view[`PCH_ST_CAP]     = EXTENDED;
    end

    // plain byte registers
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cache_line_words     <= 8'h00;
            master_latency_count <= 8'h00;
            irq_routing_line     <= 8'h00;
        end
        else if (wr && !is_opreg)
        begin
            if (word_ofs == `PCH_OFS_MISC && cfg_req_in.byte_en[0])
                cache_line_words <= cfg_req_in.data[7:0];
            if (word_ofs == `PCH_OFS_MISC && cfg_req_in.byte_en[1])
                master_latency_count <= cfg_req_in.data[15:8];
            if (word_ofs == `PCH_OFS_IRQ && cfg_req_in.byte_en[0])
                irq_routing_line <= cfg_req_in.data[7:0];
        end
    end

    // power state field exists only on the extended variant
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            power_control_state <= 16'h0000;
        else if (EXTENDED && wr && !is_opreg && word_ofs == `PCH_OFS_PM_CSR && cfg_req_in.byte_en[0])
            power_control_state <= {8'h00, cfg_req_in.data[7:0]} & `PCH_PM_STATE_MASK;
    end

    pch_bar #(.SIZE_MASK(`PCH_IO_BAR_MASK), .FIXED(`PCH_IO_BAR_FIX)) u_io_bar (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .enable_in  (1'b1),
        .write_in   (wr && !is_opreg && word_ofs == `PCH_OFS_IO_BAR),
        .byte_en_in (cfg_req_in.byte_en),
        .data_in    (cfg_req_in.data),
        .value_out  (io_bar_val)
    );
    pch_bar #(.SIZE_MASK(`PCH_MEM_BAR_MASK), .FIXED(32'h0000_0000)) u_mem_bar (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .enable_in  (1'b1),
        .write_in   (wr && !is_opreg && word_ofs == `PCH_OFS_MEM_BAR),
        .byte_en_in (cfg_req_in.byte_en),
        .data_in    (cfg_req_in.data),
        .value_out  (mem_bar_val)
    );
    pch_bar #(.SIZE_MASK(`PCH_RAM_BAR_MASK), .FIXED(32'h0000_0000)) u_ram_bar (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .enable_in  (ram_bar_enabled),
        .write_in   (wr && !is_opreg && word_ofs == `PCH_OFS_RAM_BAR),
        .byte_en_in (cfg_req_in.byte_en),
        .data_in    (cfg_req_in.data),
        .value_out  (ram_bar_val)
    );
    pch_bar #(.SIZE_MASK(ROM_MASK | 32'h0000_0001), .FIXED(32'h0000_0000)) u_rom_bar (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .enable_in  (rom_bar_enabled),
        .write_in   (wr && !is_opreg && word_ofs == `PCH_OFS_ROM_BAR),
        .byte_en_in (cfg_req_in.byte_en),
        .data_in    (cfg_req_in.data),
        .value_out  (rom_bar_val)
    );
    assign io_base_out  = io_bar_val;
    assign mem_base_out = mem_bar_val;
    assign ram_base_out = ram_bar_val;
    assign rom_base_out = rom_bar_val;

    // read mux; anything not listed reads zero, writes to it are dropped
    always_comb
    begin
        next_read_data = 32'h0000_0000;
        if (is_opreg)
            next_read_data = opreg_read_data_in;
        else
        begin
            unique case (word_ofs)
                `PCH_OFS_IDENT:   next_read_data = {PART_ID, MAKER_ID};
                `PCH_OFS_CMDSTAT: next_read_data = {status_view, command};
                `PCH_OFS_CLASS:   next_read_data = {`PCH_CLASS_CODE, REVISION};
                `PCH_OFS_MISC:    next_read_data = {8'h00, `PCH_HDR_TYPE, master_latency_count, cache_line_words};
                `PCH_OFS_IO_BAR:  next_read_data = io_bar_val;
                `PCH_OFS_MEM_BAR: next_read_data = mem_bar_val;
                `PCH_OFS_RAM_BAR: next_read_data = ram_bar_val;
                `PCH_OFS_SUBSYS:  next_read_data = {16'h0000, BOARD_MAKER};
                `PCH_OFS_ROM_BAR: next_read_data = rom_bar_val;
                `PCH_OFS_CAP_PTR: next_read_data = EXTENDED ? {24'h00_0000, `PCH_CAP_START} : 32'h0000_0000;
                `PCH_OFS_IRQ:     next_read_data = {`PCH_MAX_LAT, `PCH_MIN_GNT, `PCH_IRQ_PIN, irq_routing_line};
                `PCH_OFS_PM_CAP:  next_read_data = EXTENDED ? {24'h00_0000, `PCH_CAP_PM_ID} : 32'h0000_0000;
                `PCH_OFS_PM_CSR:  next_read_data = EXTENDED ? {16'h0000, power_control_state} : 32'h0000_0000;
                default:          next_read_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cfg_read_data_out <= 32'h0000_0000;
        else if (cfg_req_in.valid && !cfg_req_in.write)
            cfg_read_data_out <= next_read_data;
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cfg_done_out <= 1'b0;
        else
            cfg_done_out <= cfg_req_in.valid;
    end

    // a zero command leaves no claim or master enable standing
    property p_zero_command;
        @(posedge clock_in) disable iff (!reset_n_in)
        (command == 16'h0000) |-> !(enables_out.io_claim_en || enables_out.mem_claim_en || enables_out.master_en);
    endproperty
    a_zero_command: assert property (p_zero_command) else $error("enables active with zero command");

    property p_cmd_reserved;
        @(posedge clock_in) disable iff (!reset_n_in)
        (command & ~`PCH_CMD_MASK) == 16'h0000;
    endproperty
    a_cmd_reserved: assert property (p_cmd_reserved) else $error("unimplemented command bit stored");

    property p_serr_gate;
        @(posedge clock_in) disable iff (!reset_n_in)
        serr_drive_out |-> $past(command[`PCH_CMD_SERR] && command[`PCH_CMD_PERR] && addr_parity_err_in);
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("error driver without both enables");

    property p_mwi_gate;
        @(posedge clock_in) disable iff (!reset_n_in)
        enables_out.mwi_en |-> (command[`PCH_CMD_MWI] && dma_test_control_three_bit0_in);
    endproperty
    a_mwi_gate: assert property (p_mwi_gate) else $error("invalidate writes enabled without both bits");

    property p_par_det_set;
        @(posedge clock_in) disable iff (!reset_n_in)
        events_in.parity_detected |=> status_flags[`PCH_ST_PAR_DET];
    endproperty
    a_par_det_set: assert property (p_par_det_set) else $error("parity detect flag not set");

    property p_serr_flag;
        @(posedge clock_in) disable iff (!reset_n_in)
        serr_drive_out |=> status_flags[`PCH_ST_SERR];
    endproperty
    a_serr_flag: assert property (p_serr_flag) else $error("system error flag not set");

    property p_never_set_by_write;
        @(posedge clock_in) disable iff (!reset_n_in)
        ($rose(status_flags[`PCH_ST_MST_ABT])) |-> $past(events_in.master_abort && !special_cycle_in);
    endproperty
    a_never_set_by_write: assert property (p_never_set_by_write) else $error("abort flag set without event");

    property p_status_zero_bits;
        @(posedge clock_in) disable iff (!reset_n_in)
        (status_view[3:0] == 4'h0) && (status_view[7:5] == 3'h0) && !status_view[11];
    endproperty
    a_status_zero_bits: assert property (p_status_zero_bits) else $error("reserved status bit nonzero");

    property p_unsupported_zero;
        @(posedge clock_in) disable iff (!reset_n_in)
        (cfg_req_in.valid && !cfg_req_in.write && !is_opreg
            && word_ofs >= (EXTENDED ? `PCH_OFS_UNSUP_EXT : `PCH_OFS_UNSUP_BASE))
        |=> cfg_read_data_out == 32'h0000_0000;
    endproperty
    a_unsupported_zero: assert property (p_unsupported_zero) else $error("unsupported location read nonzero");
endmodule : pch_config_header

/* tb/pch_host_model.sv */
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
module pch_host_model (
    input  wire logic             clock_in,
    input  wire logic             done_in,
    input  wire logic      [31:0] read_data_in,
    output pch_pkg::pch_cfg_req_t req_out
);
    initial req_out = '0;
    // one request per call; released lines show inverted data, never the last value
    task automatic access(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge clock_in);
        req_out <= '{1'b1, wr, ofs, be, wd};
        @(posedge clock_in);
        req_out <= '{1'b0, ~wr, ~ofs, ~be, ~wd};
        #1;
        ok = done_in;
        rd = read_data_in;
    endtask : access
endmodule : pch_host_model

/* tb/testbench.sv */
// self-checking bench for the configuration header bank
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
    localparam logic [15:0] PART  = 16'h5678; // arbitrary value
    logic                  clock_in, reset_n_in, done, sel, serr, smp, dma0, spc, apar, ok, sel_seen;
    logic           [31:0] rd_data, op_data, io_b, mem_b, ram_b, rom_b, rv, rd_x;
    logic            [7:0] straps;
    pch_pkg::pch_cfg_req_t req;
    pch_pkg::pch_events_t  ev;
    pch_pkg::pch_enables_t en;
    int                    n_mismatch = 0, checks_done = 0, cycles = 0;

    pch_config_header #(.MAKER_ID(MAKER), .PART_ID(PART), .REVISION(8'h01), .ROM_MASK(32'hffff_8000)) u_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .cfg_req_in(req), .cfg_read_data_out(rd_data),
        .cfg_done_out(done), .opreg_sel_out(sel), .opreg_read_data_in(op_data), .strap_bus_in(straps),
        .strap_sample_in(smp), .dma_test_control_three_bit0_in(dma0), .events_in(ev),
        .special_cycle_in(spc), .addr_parity_err_in(apar), .enables_out(en), .serr_drive_out(serr),
        .io_base_out(io_b), .mem_base_out(mem_b), .ram_base_out(ram_b), .rom_base_out(rom_b));
    pch_host_model u_host (.clock_in(clock_in), .done_in(done), .read_data_in(rd_data), .req_out(req));
    // extended variant shares the request lines; only its read data is judged
    pch_config_header #(.EXTENDED(1'b1), .MAKER_ID(MAKER), .PART_ID(PART)) u_dut_ext (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .cfg_req_in(req), .cfg_read_data_out(rd_x),
        .cfg_done_out(), .opreg_sel_out(), .opreg_read_data_in(op_data), .strap_bus_in(straps),
        .strap_sample_in(smp), .dma_test_control_three_bit0_in(dma0), .events_in(ev),
        .special_cycle_in(spc), .addr_parity_err_in(apar), .enables_out(), .serr_drive_out(),
        .io_base_out(), .mem_base_out(), .ram_base_out(), .rom_base_out());

    initial
    begin
        clock_in = 0;
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        sel_seen <= sel_seen | sel;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
        u_host.access(1'b1, ofs, be, d, rv, ok);
        chk("write done", 32'h1, {31'h0, ok});
    endtask : wr
    task automatic rdx(input logic [7:0] ofs, input logic [31:0] exp);
        u_host.access(1'b0, ofs, 4'hf, 32'h0, rv, ok);
        chk("read done", 32'h1, {31'h0, ok});
        chk($sformatf("offset %h", ofs), exp, rv);
    endtask : rdx
    task automatic do_reset(input logic [7:0] s);
        reset_n_in <= 0;
        straps <= s;
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1;
        @(posedge clock_in) smp <= 1;
        @(posedge clock_in) smp <= 0;
    endtask : do_reset
    task automatic pulse(input pch_pkg::pch_events_t e);
        @(posedge clock_in) ev <= e;
        @(posedge clock_in) ev <= '0;
    endtask : pulse

    task automatic t_ident;
        rdx(8'h00, {PART, MAKER});
        wr(8'h00, 4'hf, 32'hffff_ffff);
        rdx(8'h00, {PART, MAKER});
        rdx(8'h04, 32'h0200_0000);
        rdx(8'h08, 32'h0100_0001);
        wr(8'h3c, 4'h1, 32'hffff_ffa5);
        rdx(8'h3c, 32'h4011_01a5);
        $display("test ident done");
    endtask : t_ident
    task automatic t_unsup;
        logic [7:0] ofs [9] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h34, 8'h38, 8'h40, 8'h44, 8'h7c};
        foreach (ofs[i])
        begin
            wr(ofs[i], 4'hf, 32'hffff_ffff);
            rdx(ofs[i], 32'h0);
        end
        $display("test unsupported done");
    endtask : t_unsup
    task automatic t_command;
        logic [15:0] cmd [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0040, 16'h0100, 16'h0140, 16'hfea8};
        logic [6:0]  exp [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h07, 7'h00};
        wr(8'h04, 4'h3, 32'h0000_ffff);
        rdx(8'h04, 32'h0200_0157);
        chk("enables", 32'h77, {25'h0, en});
        @(posedge clock_in) dma0 <= 1;
        foreach (cmd[i])
        begin
            wr(8'h04, 4'h3, {16'h0, cmd[i]});
            chk("enables", {25'h0, exp[i]}, {25'h0, en});
        end
        wr(8'h04, 4'h3, 32'h0);
        chk("enables", 32'h0, {25'h0, en});
        $display("test command done");
    endtask : t_command
    task automatic t_status;
        pulse(5'b10000);
        rdx(8'h04, 32'h8200_0000);
        @(posedge clock_in) spc <= 1;
        pulse(5'b00100);
        spc <= 0;
        rdx(8'h04, 32'h8200_0000);
        pulse(5'b00100);
        pulse(5'b00010);
        pulse(5'b00001);
        rdx(8'h04, 32'hb200_0000);
        wr(8'h04, 4'hc, 32'h8000_0000);
        rdx(8'h04, 32'h3200_0000);
        wr(8'h04, 4'h3, 32'h0000_0100);
        @(posedge clock_in) apar <= 1;
        @(posedge clock_in) apar <= 0;
        #1 chk("serr", 32'h0, {31'h0, serr});
        wr(8'h04, 4'h3, 32'h0000_0140);
        pulse(5'b00001);
        @(posedge clock_in) apar <= 1;
        @(posedge clock_in) apar <= 0;
        #1 chk("serr", 32'h1, {31'h0, serr});
        rdx(8'h04, 32'h7300_0140);
        wr(8'h04, 4'hc, 32'hffff_0000);
        rdx(8'h04, 32'h0200_0140);
        $display("test status done");
    endtask : t_status
    task automatic t_opreg;
        op_data <= 32'hc0de_5a5a;
        sel_seen <= 0;
        rdx(8'h80, 32'hc0de_5a5a);
        chk("opreg select", 32'h1, {31'h0, sel_seen});
        $display("test opreg done");
    endtask : t_opreg
    task automatic t_bars;
        do_reset(8'hff);
        wr(8'h10, 4'hf, 32'hffff_ffff);
        rdx(8'h10, 32'hffff_ff01);
        chk("io base", 32'hffff_ff01, io_b);
        wr(8'h14, 4'hf, 32'hffff_ffff);
        rdx(8'h14, 32'hffff_ff00);
        chk("mem base", 32'hffff_ff00, mem_b);
        wr(8'h18, 4'hf, 32'hffff_ffff);
        rdx(8'h18, 32'hffff_f000);
        chk("ram base", 32'hffff_f000, ram_b);
        wr(8'h30, 4'hf, 32'hffff_ffff);
        rdx(8'h30, 32'h0);
        chk("rom base", 32'h0, rom_b);
        do_reset(8'hdf);
        wr(8'h18, 4'hf, 32'hffff_ffff);
        rdx(8'h18, 32'h0);
        chk("ram base", 32'h0, ram_b);
        wr(8'h30, 4'hf, 32'hffff_ffff);
        rdx(8'h30, 32'hffff_8001);
        chk("rom base", 32'hffff_8001, rom_b);
        $display("test bars done");
    endtask : t_bars
    task automatic t_ext;
        rdx(8'h34, 32'h0);
        chk("ext offset 34", 32'h0000_0040, rd_x);
        rdx(8'h40, 32'h0);
        chk("ext offset 40", 32'h0000_0001, rd_x);
        wr(8'h44, 4'hf, 32'hffff_ffff);
        rdx(8'h44, 32'h0);
        chk("ext offset 44", 32'h0000_0003, rd_x);
        wr(8'h48, 4'hf, 32'hffff_ffff);
        rdx(8'h48, 32'h0);
        chk("ext offset 48", 32'h0, rd_x);
        rdx(8'h04, 32'h0200_0000);
        chk("ext status", 32'h0210_0000, rd_x);
        $display("test extended done");
    endtask : t_ext

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    initial
    begin
        {reset_n_in, smp, dma0, spc, apar, sel_seen} = '0;
        {op_data, straps, ev} = '0;
        do_reset(8'hff);
        t_ident();
        t_unsup();
        t_command();
        t_status();
        t_opreg();
        t_bars();
        t_ext();
        final_report();
    end
endmodule : testbench
